// [aamc_conv_model.sv]
`timescale 1ns/1ns
module aamc_conv_model (
  input  wire        clk_i,
  input  wire        req_i,
  input  wire [1:0]  chan_i,
  input  wire [3:0]  acc_dly_i,
  input  wire [23:0] res_i,
  output reg         accept_o,
  output reg         done_o,
  output reg  [7:0]  result_o
);
  reg [1:0] ch;
  initial begin
    accept_o = 1'b0;
    done_o = 1'b0;
    result_o = 8'h5a;
  end
  always begin
    @(posedge clk_i);
    if (req_i === 1'b1) begin
      ch = chan_i;
      repeat (acc_dly_i) @(posedge clk_i);
      accept_o <= 1'b1;
      @(posedge clk_i);
      accept_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      done_o <= 1'b1;
      result_o <= res_i[ch*8 +: 8];
      @(posedge clk_i);
      done_o <= 1'b0;
      // Stale data must never pass for a result
      result_o <= ~result_o;
    end
  end
endmodule // aamc_conv_model

// [aamc_ctrl.v]
`timescale 1ns/1ns
`include "aamc_map.vh"
module aamc_ctrl #(
  parameter [31:0] MINUTE_CYCLES = `AAMC_MINUTE_CYCLES
) (
  input  wire       CLK_I,
  input  wire       RST_B_I,
  input  wire [7:0] SFR_ADDR_I,
  input  wire       SFR_WR_I,
  input  wire       SFR_RD_I,
  input  wire [7:0] SFR_WDATA_I,
  input  wire       BATTERY_ACTIVE_MODE_I,
  input  wire       SLEEP_CORE_OFF_MODE_I,
  input  wire       PLL_LOCK_LOSS_RESET_I,
  input  wire       CONV_ACCEPT_I,
  input  wire       CONV_DONE_I,
  input  wire [7:0] CONV_RESULT_I,
  output reg  [7:0] SFR_RDATA_O,
  output reg        CONV_REQ_O,
  output reg  [1:0] CONV_CHAN_O,
  output reg        TEMP_IRQ_O,
  output reg        SUPPLY_IRQ_O,
  output reg        BATT_IRQ_O,
  output reg        LOW_BATTERY_FLAG_O,
  output reg        PLL_FAULT_INDICATION_O
);
  localparam [1:0] CH_BAT = 2'h0;
  localparam [1:0] CH_TMP = 2'h1;
  localparam [1:0] CH_SUP = 2'h2;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Minutes between strobes; 0 means off
  function [4:0] period_min;
    input [1:0] code;
    input       is_bat;
    begin
      case (code)
        2'h1:    period_min = is_bat ? 5'd16 : 5'd8;
        2'h2:    period_min = is_bat ? 5'd4 : 5'd2;
        2'h3:    period_min = 5'd1;
        default: period_min = 5'd0;
      endcase
    end
  endfunction

  // Change test against last interrupting value
  function delta_hit;
    input [2:0] code;
    input [7:0] new_v;
    input [7:0] old_v;
    reg   [7:0] diff;
    begin
      diff = (new_v > old_v) ? (new_v - old_v) : (old_v - new_v);
      if (code == `AAMC_DELTA_NEVER)
        delta_hit = 1'b0;
      else if (code == `AAMC_DELTA_ALWAYS)
        delta_hit = 1'b1;
      else
        delta_hit = (diff > {5'h00, code});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  period_cfg_ff;
  reg  [7:0]  delta_cfg_ff;
  reg  [7:0]  batt_thresh_ff;
  reg  [2:0]  single_req_ff;
  reg  [2:0]  bg_pend_ff;
  reg  [31:0] minute_cnt_ff;
  reg  [4:0]  min_cnt_ff [0:2];
  reg  [1:0]  state_ff;
  reg  [1:0]  cur_chan_ff;
  reg         cur_single_ff;
  reg  [7:0]  tmp_shadow_ff;
  reg  [7:0]  sup_shadow_ff;
  reg  [7:0]  bat_shadow_ff;
  // Last interrupting value of the channel in flight
  wire [7:0]  mem_rdata;
  wire        minute_tick = (minute_cnt_ff == MINUTE_CYCLES - 32'd1);
  // Battery-active mode stops scheduling unless sleep-core-off mode is also set
  wire        bg_allowed  = !BATTERY_ACTIVE_MODE_I || SLEEP_CORE_OFF_MODE_I;
  wire        wr_start    = SFR_WR_I && SFR_ADDR_I == `AAMC_ADDR_CONV_START;
  wire [2:0]  req_all     = single_req_ff | bg_pend_ff;
  reg  [2:0]  strobe;
  reg  [1:0]  pick;
  reg         any_req;
  reg         done_irq;
  reg  [1:0]  wr_idx;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe generation per channel
  always @* begin
    strobe = 3'h0;
    if (minute_tick && bg_allowed) begin
      strobe[CH_BAT] = period_min(period_cfg_ff[`AAMC_PER_BAT_HI:`AAMC_PER_BAT_LO], 1'b1) != 5'd0 &&
                       min_cnt_ff[CH_BAT] >= period_min(period_cfg_ff[3:2], 1'b1) - 5'd1;
      strobe[CH_TMP] = period_min(period_cfg_ff[`AAMC_PER_TMP_HI:`AAMC_PER_TMP_LO], 1'b0) != 5'd0 &&
                       min_cnt_ff[CH_TMP] >= period_min(period_cfg_ff[1:0], 1'b0) - 5'd1;
      strobe[CH_SUP] = period_min(period_cfg_ff[`AAMC_PER_SUP_HI:`AAMC_PER_SUP_LO], 1'b0) != 5'd0 &&
                       min_cnt_ff[CH_SUP] >= period_min(period_cfg_ff[5:4], 1'b0) - 5'd1;
    end
  end

  // Fixed priority: temperature, battery, supply
  always @* begin
    any_req = |req_all;
    if (req_all[CH_TMP])
      pick = CH_TMP;
    else if (req_all[CH_BAT])
      pick = CH_BAT;
    else
      pick = CH_SUP;
  end

  // Completion decision and result routing
  always @* begin
    done_irq = 1'b0;
    wr_idx   = 2'h3;
    if (state_ff == ST_WAIT && CONV_DONE_I) begin
      case (cur_chan_ff)
        CH_TMP: begin
          done_irq = cur_single_ff ||
                     delta_hit(delta_cfg_ff[`AAMC_DLT_TMP_HI:`AAMC_DLT_TMP_LO], CONV_RESULT_I, mem_rdata);
          wr_idx   = done_irq ? CH_TMP : 2'h3;
        end
        CH_SUP: begin
          done_irq = cur_single_ff ||
                     delta_hit(delta_cfg_ff[`AAMC_DLT_SUP_HI:`AAMC_DLT_SUP_LO], CONV_RESULT_I, mem_rdata);
          wr_idx   = done_irq ? CH_SUP : 2'h3;
        end
        CH_BAT: begin
          done_irq = 1'b1;
          wr_idx   = CH_BAT;
        end
        default: begin
          done_irq = 1'b0;
          wr_idx   = 2'h3;
        end
      endcase
    end
  end

  aamc_result_mem u_mem (
    .clk_i     (CLK_I),
    .rst_b_i   (RST_B_I),
    .wr_en_i   (wr_idx != 2'h3),
    .wr_idx_i  (wr_idx),
    .wr_data_i (CONV_RESULT_I),
    // Channel is fixed from request on, so read data settle before done
    .rd_idx_i  (cur_chan_ff),
    .rd_data_o (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequential logic
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      period_cfg_ff          <= `AAMC_RST_PERIOD_CFG;
      delta_cfg_ff           <= `AAMC_RST_DELTA_CFG;
      batt_thresh_ff         <= `AAMC_RST_BATT_THRESH;
      single_req_ff          <= 3'h0;
      bg_pend_ff             <= 3'h0;
      minute_cnt_ff          <= 32'h0;
      for (i = 0; i < 3; i = i + 1) begin
        min_cnt_ff[i] <= 5'h00;
      end
      state_ff               <= ST_IDLE;
      cur_chan_ff            <= CH_BAT;
      cur_single_ff          <= 1'b0;
      tmp_shadow_ff          <= 8'h00;
      sup_shadow_ff          <= 8'h00;
      bat_shadow_ff          <= 8'h00;
      SFR_RDATA_O            <= 8'h00;
      CONV_REQ_O             <= 1'b0;
      CONV_CHAN_O            <= 2'h0;
      TEMP_IRQ_O             <= 1'b0;
      SUPPLY_IRQ_O           <= 1'b0;
      BATT_IRQ_O             <= 1'b0;
      LOW_BATTERY_FLAG_O     <= 1'b0;
      PLL_FAULT_INDICATION_O <= 1'b0;
    end else begin
      // Minute base and per-channel minute counters
      minute_cnt_ff <= minute_tick ? 32'h0 : minute_cnt_ff + 32'd1;
      for (i = 0; i < 3; i = i + 1) begin
        if (strobe[i])
          min_cnt_ff[i] <= 5'h00;
        else if (minute_tick && min_cnt_ff[i] != 5'h1f)
          min_cnt_ff[i] <= min_cnt_ff[i] + 5'd1; // Saturates: a wrap would skip a strobe
      end

      // Config writes; bits are stored as written except delta bits 7:6, which store as zero
      if (SFR_WR_I) begin
        case (SFR_ADDR_I)
          `AAMC_ADDR_PERIOD_CFG:  period_cfg_ff  <= SFR_WDATA_I;
          `AAMC_ADDR_DELTA_CFG:   delta_cfg_ff   <= {2'h0, SFR_WDATA_I[5:0]};
          `AAMC_ADDR_BATT_THRESH: batt_thresh_ff <= SFR_WDATA_I;
          default: ;
        endcase
      end

      // Start bits: written ones set, acceptance clears; set beats clear
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_start && SFR_WDATA_I[i])
          single_req_ff[i] <= 1'b1;
        else if (state_ff == ST_REQ && CONV_ACCEPT_I && cur_single_ff && cur_chan_ff == i[1:0])
          single_req_ff[i] <= 1'b0;
        if (strobe[i])
          bg_pend_ff[i] <= 1'b1;
        else if (state_ff == ST_REQ && CONV_ACCEPT_I && !cur_single_ff && cur_chan_ff == i[1:0])
          bg_pend_ff[i] <= 1'b0;
      end

      // Fault: lock-loss set wins over acknowledge
      if (PLL_LOCK_LOSS_RESET_I)
        PLL_FAULT_INDICATION_O <= 1'b1;
      else if (wr_start && SFR_WDATA_I[`AAMC_GO_PLL_ACK])
        PLL_FAULT_INDICATION_O <= 1'b0;

      // Converter sequencer, one at a time
      TEMP_IRQ_O   <= 1'b0;
      SUPPLY_IRQ_O <= 1'b0;
      BATT_IRQ_O   <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (any_req) begin
            cur_chan_ff   <= pick;
            cur_single_ff <= single_req_ff[pick];
            CONV_CHAN_O   <= pick;
            CONV_REQ_O    <= 1'b1;
            state_ff      <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (CONV_ACCEPT_I) begin
            CONV_REQ_O <= 1'b0;
            state_ff   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (CONV_DONE_I) begin
            state_ff <= ST_IDLE;
            case (cur_chan_ff)
              CH_TMP: begin
                TEMP_IRQ_O <= done_irq;
                if (done_irq) begin
                  tmp_shadow_ff <= CONV_RESULT_I;
                end
              end
              CH_SUP: begin
                SUPPLY_IRQ_O <= done_irq;
                if (done_irq) begin
                  sup_shadow_ff <= CONV_RESULT_I;
                end
              end
              default: begin
                bat_shadow_ff <= CONV_RESULT_I;
                BATT_IRQ_O    <= CONV_RESULT_I < batt_thresh_ff;
                if (CONV_RESULT_I < batt_thresh_ff)
                  LOW_BATTERY_FLAG_O <= 1'b1;
              end
            endcase
          end
        end
        default: state_ff <= ST_IDLE;
      endcase

      // Flag is owned by the flag register; clear on any threshold write unless a result completes that cycle
      if (SFR_WR_I && SFR_ADDR_I == `AAMC_ADDR_BATT_THRESH && !(state_ff == ST_WAIT && CONV_DONE_I))
        LOW_BATTERY_FLAG_O <= 1'b0;

      // Read path, one-cycle latency; data hold between read strobes
      if (SFR_RD_I) begin
        case (SFR_ADDR_I)
          `AAMC_ADDR_PERIOD_CFG:  SFR_RDATA_O <= period_cfg_ff;
          `AAMC_ADDR_DELTA_CFG:   SFR_RDATA_O <= delta_cfg_ff;
          `AAMC_ADDR_BATT_THRESH: SFR_RDATA_O <= batt_thresh_ff;
          `AAMC_ADDR_CONV_START:  SFR_RDATA_O <= {5'h00, single_req_ff};
          `AAMC_ADDR_TEMP_RESULT: SFR_RDATA_O <= tmp_shadow_ff;
          `AAMC_ADDR_BATT_RESULT: SFR_RDATA_O <= bat_shadow_ff;
          `AAMC_ADDR_SUPPLY_RESULT: SFR_RDATA_O <= sup_shadow_ff;
          default:                SFR_RDATA_O <= 8'h00;
        endcase
      end
    end
  end
endmodule // aamc_ctrl

// [aamc_ctrl_asserts.sv]
`timescale 1ns/1ns
module aamc_ctrl_chk (
  input wire       CLK_I,
  input wire       RST_B_I,
  input wire [7:0] SFR_ADDR_I,
  input wire       SFR_WR_I,
  input wire [7:0] SFR_WDATA_I,
  input wire       PLL_LOCK_LOSS_RESET_I,
  input wire       CONV_ACCEPT_I,
  input wire       CONV_DONE_I,
  input wire       CONV_REQ_O,
  input wire [1:0] CONV_CHAN_O,
  input wire       TEMP_IRQ_O,
  input wire       SUPPLY_IRQ_O,
  input wire       BATT_IRQ_O,
  input wire       LOW_BATTERY_FLAG_O,
  input wire       PLL_FAULT_INDICATION_O
);
  wire ack = SFR_WR_I && SFR_ADDR_I == 8'hd8 && SFR_WDATA_I[7];
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////
  property p_req_hold;
    CONV_REQ_O && !CONV_ACCEPT_I |=> CONV_REQ_O && $stable(CONV_CHAN_O);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request moved before acceptance");
  property p_req_drop;
    CONV_REQ_O && CONV_ACCEPT_I |=> !CONV_REQ_O || CONV_CHAN_O != $past(CONV_CHAN_O);
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("accepted request still raised");
  property p_tirq;
    TEMP_IRQ_O |-> $past(CONV_DONE_I) ##1 !TEMP_IRQ_O;
  endproperty
  a_tirq: assert property (p_tirq)
    else $error("temperature pulse without result");
  property p_sirq;
    SUPPLY_IRQ_O |-> $past(CONV_DONE_I) ##1 !SUPPLY_IRQ_O;
  endproperty
  a_sirq: assert property (p_sirq)
    else $error("supply pulse without result");
  property p_birq;
    BATT_IRQ_O |-> $past(CONV_DONE_I) && LOW_BATTERY_FLAG_O;
  endproperty
  a_birq: assert property (p_birq)
    else $error("battery pulse without flag");
  property p_pll_set;
    PLL_LOCK_LOSS_RESET_I |=> PLL_FAULT_INDICATION_O;
  endproperty
  a_pll_set: assert property (p_pll_set)
    else $error("fault not raised");
  property p_pll_hold;
    PLL_FAULT_INDICATION_O && !ack |=> PLL_FAULT_INDICATION_O;
  endproperty
  a_pll_hold: assert property (p_pll_hold)
    else $error("fault cleared without acknowledge");
  property p_pll_ack;
    ack && !PLL_LOCK_LOSS_RESET_I |=> !PLL_FAULT_INDICATION_O;
  endproperty
  a_pll_ack: assert property (p_pll_ack)
    else $error("acknowledge ignored");
  c_tirq: cover property (TEMP_IRQ_O);
  c_birq: cover property (BATT_IRQ_O);
  c_ack: cover property (ack && PLL_FAULT_INDICATION_O);
endmodule // aamc_ctrl_chk

// [aamc_map.vh]
`ifndef AAMC_MAP_VH
`define AAMC_MAP_VH
// Register addresses on the special-function register port
`define AAMC_ADDR_TEMP_RESULT    8'hd7
`define AAMC_ADDR_CONV_START     8'hd8
`define AAMC_ADDR_BATT_RESULT    8'hdf
`define AAMC_ADDR_SUPPLY_RESULT  8'hef
`define AAMC_ADDR_DELTA_CFG      8'hf3
`define AAMC_ADDR_PERIOD_CFG     8'hf9
`define AAMC_ADDR_BATT_THRESH    8'hfa
// Field positions
`define AAMC_PER_RSVD_HI         7
`define AAMC_PER_RSVD_LO         6
`define AAMC_PER_SUP_HI          5
`define AAMC_PER_SUP_LO          4
`define AAMC_PER_BAT_HI          3
`define AAMC_PER_BAT_LO          2
`define AAMC_PER_TMP_HI          1
`define AAMC_PER_TMP_LO          0
`define AAMC_DLT_TMP_HI          5
`define AAMC_DLT_TMP_LO          3
`define AAMC_DLT_SUP_HI          2
`define AAMC_DLT_SUP_LO          0
`define AAMC_GO_PLL_ACK          7
`define AAMC_GO_SUP              2
`define AAMC_GO_TMP              1
`define AAMC_GO_BAT              0
// Reset values
`define AAMC_RST_PERIOD_CFG      8'h00
`define AAMC_RST_DELTA_CFG       8'h00
`define AAMC_RST_CONV_START      8'h00
`define AAMC_RST_BATT_THRESH     8'h00
`define AAMC_RST_RESULT          8'h00
// Delta codes
`define AAMC_DELTA_NEVER         3'h0
`define AAMC_DELTA_ALWAYS        3'h7
// Timing: 1 minute tick at 10 MHz
`define AAMC_MINUTE_S            60
`define AAMC_CLK_HZ              10000000
`define AAMC_MINUTE_CYCLES       (`AAMC_MINUTE_S * `AAMC_CLK_HZ)
`endif

// [aamc_result_mem.v]
`timescale 1ns/1ns
// Holds the three 8-bit conversion results; read data registered.
module aamc_result_mem (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       wr_en_i,
  input  wire [1:0] wr_idx_i,
  input  wire [7:0] wr_data_i,
  input  wire [1:0] rd_idx_i,
  output reg  [7:0] rd_data_o
);
  reg [7:0] mem_ff [0:2];
  integer   k;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (k = 0; k < 3; k = k + 1) begin
        mem_ff[k] <= 8'h00;
      end
      rd_data_o <= 8'h00;
    end else begin
      if (wr_en_i && wr_idx_i != 2'h3) begin
        mem_ff[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= (rd_idx_i == 2'h3) ? 8'h00 : mem_ff[rd_idx_i];
    end
  end
endmodule // aamc_result_mem

// [tb_aamc_ctrl.sv]
`timescale 1ns/1ns
module tb_aamc_ctrl;
  reg         clk, rst_b, wr_s, rd_s, battery_active_mode, sleep_core_off_mode, pll;
  reg  [7:0]  addr, wdata;
  reg  [3:0]  dly;
  reg  [23:0] res;
  wire        acc, done, req, tirq, sirq, birq, lowb, fault;
  wire [7:0]  rdata, cres;
  wire [1:0]  chan;
  integer     n_mismatch, n_tests, nt, ns, nb, na, a0, i, j, m;
  aamc_ctrl #(.MINUTE_CYCLES(20)) dut_u (.CLK_I(clk), .RST_B_I(rst_b), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr_s), .SFR_RD_I(rd_s), .SFR_WDATA_I(wdata), .BATTERY_ACTIVE_MODE_I(battery_active_mode),
    .SLEEP_CORE_OFF_MODE_I(sleep_core_off_mode), .PLL_LOCK_LOSS_RESET_I(pll), .CONV_ACCEPT_I(acc),
    .CONV_DONE_I(done), .CONV_RESULT_I(cres), .SFR_RDATA_O(rdata), .CONV_REQ_O(req),
    .CONV_CHAN_O(chan), .TEMP_IRQ_O(tirq), .SUPPLY_IRQ_O(sirq), .BATT_IRQ_O(birq),
    .LOW_BATTERY_FLAG_O(lowb), .PLL_FAULT_INDICATION_O(fault));
  aamc_conv_model conv_u (.clk_i(clk), .req_i(req), .chan_i(chan), .acc_dly_i(dly),
    .res_i(res), .accept_o(acc), .done_o(done), .result_o(cres));
  ////////////////////////////////////////////////////////////
  task test_done;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input string nm);
    begin
      @(negedge clk);
      addr = a;
      rd_s = 1'b1;
      @(negedge clk);
      rd_s = 1'b0;
      chk(nm, {24'h0, e}, {24'h0, rdata});
    end
  endtask
  // Time between two successive strobes of one channel
  task per(input [7:0] cfg, input [1:0] c, input integer mm);
    integer t, t0, k;
    reg last, now;
    begin
      wr(8'hf9, cfg);
      t = 0;
      t0 = 0;
      k = 0;
      last = 1'b0;
      while (k < 2 && t < 50 * mm) begin
        @(negedge clk);
        t = t + 1;
        now = req === 1'b1 && chan === c;
        if (now && !last) begin
          k = k + 1;
          if (k == 1) t0 = t;
        end
        last = now;
      end
      chk("strobe period", mm * 20, t - t0);
      wr(8'hf9, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (tirq === 1'b1) nt = nt + 1;
    if (sirq === 1'b1) ns = ns + 1;
    if (birq === 1'b1) nb = nb + 1;
    if (acc === 1'b1) na = na + 1;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    {rst_b, wr_s, rd_s, battery_active_mode, sleep_core_off_mode, pll, addr, wdata} = 0;
    {n_mismatch, n_tests, nt, ns, nb, na} = 0;
    dly = 4'h4;
    res = 24'h804010;
    wt(2);
    rst_b = 1'b1;
    rd(8'hf9, 8'h00, "period reset");
    rd(8'hfa, 8'h00, "threshold reset");
    rd(8'hd8, 8'h00, "start reset");
    rd(8'h00, 8'h00, "unmapped");
    wr(8'hfa, 8'h80);
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'hd8, 8'h01 << i);
      rd(8'hd8, 8'h01 << i, "start bit set");
      wt(20);
      rd(8'hd8, 8'h00, "start bit clear");
      rd(i == 0 ? 8'hdf : i == 1 ? 8'hd7 : 8'hef, res[i*8 +: 8], "result");
    end
    chk("low battery flag", 1, lowb);
    dly = 4'h0;
    wr(8'hd8, 8'h07);
    wt(40);
    chk("queued irqs", 32'h222, {nb[3:0], nt[3:0], ns[3:0]});
    wr(8'hfa, 8'h08);
    wr(8'hd8, 8'h01);
    wt(20);
    chk("battery above threshold", 32'h20, {nb[3:0], 3'h0, lowb});
    pll = 1'b1;
    wt(1);
    pll = 1'b0;
    wt(5);
    chk("fault held", 1, fault);
    wr(8'hd8, 8'h80);
    chk("fault acknowledged", 0, fault);
    rd(8'hd8, 8'h00, "start reserved");
    wr(8'hf3, 8'hd0);
    rd(8'hf3, 8'h10, "delta reserved");
    res[15:8] = 8'h42;
    wr(8'hf9, 8'h03);
    wt(50);
    chk("small change irqs", 2, nt);
    rd(8'hd7, 8'h40, "temp result held");
    res[15:8] = 8'h43;
    wt(30);
    chk("large change irqs", 3, nt);
    rd(8'hd7, 8'h43, "temp result new");
    wr(8'hf3, 8'h07);
    res[15:8] = 8'h00;
    a0 = ns;
    wr(8'hf9, 8'h33);
    wt(60);
    chk("temp never irq", 3, nt);
    chk("supply every irq", 1, ns >= a0 + 2);
    wr(8'hf9, 8'h00);
    wt(30);
    battery_active_mode = 1'b1;
    wr(8'hf9, 8'h3f);
    a0 = na;
    wt(80);
    chk("battery mode strobes", a0, na);
    battery_active_mode = 1'b0;
    sleep_core_off_mode = 1'b1;
    a0 = na;
    wt(80);
    chk("sleep mode strobes", 1, na >= a0 + 6);
    sleep_core_off_mode = 1'b0;
    wr(8'hf9, 8'h00);
    wt(30);
    for (i = 0; i < 3; i = i + 1)
      for (j = 0; j < 3; j = j + 1) begin
        m = j == 0 ? 1 : j == 1 ? (i == 1 ? 4 : 2) : (i == 1 ? 16 : 8);
        per((8'h03 - j) << (2 * i), i == 0 ? 2'h1 : i == 1 ? 2'h0 : 2'h2, m);
      end
    test_done;
  end
endmodule // tb_aamc_ctrl

bind aamc_ctrl aamc_ctrl_chk chk_u (.CLK_I, .RST_B_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_WDATA_I,
  .PLL_LOCK_LOSS_RESET_I, .CONV_ACCEPT_I, .CONV_DONE_I, .CONV_REQ_O, .CONV_CHAN_O, .TEMP_IRQ_O,
  .SUPPLY_IRQ_O, .BATT_IRQ_O, .LOW_BATTERY_FLAG_O, .PLL_FAULT_INDICATION_O);
